//--- bench/ihsl_board.sv
// logic board model: shifts one line into the head, then strobes the latch
// assumes clk is the head's system clock; the shift clock idles low between lines
`timescale 1ns/1ps

module ihsl_board
  import ihsl_pkg::*;
(
  input wire logic clk,
  output logic print_shift_clock,
  output logic serial_print_bit,
  output logic line_latch_strobe
);
  initial begin
    {print_shift_clock, serial_print_bit, line_latch_strobe} = 3'h2;
  end

  // ----------
  // line transfer
  // ----------
  task automatic load_line(input logic [143:0] bits, input int n);
    #3;
    for (int k = 0; k < n; k++) begin
      serial_print_bit = bits[k];
      #40 print_shift_clock = 1'b1;
      #40 print_shift_clock = 1'b0;
    end
    serial_print_bit = ~serial_print_bit;
    repeat (4) @(posedge clk);
    line_latch_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    line_latch_strobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

//--- bench/ihsl_head_monitor.sv
// pin checker of ihsl_head, bound to every instance
// assumes pins reach the outputs three clk edges after they change
`timescale 1ns/1ps

module ihsl_head_monitor
  import ihsl_pkg::*;
#(
  parameter bit COLOUR_HEAD = 1'b1,
  parameter int NOZ = 136
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic line_latch_clear,
  input wire logic block_select_0,
  input wire logic block_select_1,
  input wire logic block_select_2,
  input wire logic yellow_fire_enable,
  input wire logic magenta_fire_enable,
  input wire logic cyan_fire_enable,
  input wire logic black_fire_enable,
  input wire logic even_nozzle_fire_enable,
  input wire logic odd_nozzle_fire_enable,
  input wire logic warm_heater_drive_0,
  input wire logic warm_heater_drive_1,
  input wire logic sub_heater_drive,
  input wire logic [NOZ-1:0] nozzle_heat,
  input wire logic [7:0] heat_slot,
  input wire logic warm_heater_on_0,
  input wire logic warm_heater_on_1,
  input wire logic sub_heater_on,
  input wire logic head_type_sense_0,
  input wire logic head_type_sense_1
);
  // ----------
  // helpers
  // ----------
  localparam logic [135:0] EVEN_M = {17{8'hAA}};
  logic [2:0] up_r;
  logic [2:0] up_nxt;
  logic [NOZ-1:0] slot_m;
  wire ok = up_r == 3'h7;
  wire cok = ok && COLOUR_HEAD;
  wire [2:0] sel = {block_select_2, block_select_1, block_select_0};
  wire [1:0] par_en = {even_nozzle_fire_enable, odd_nozzle_fire_enable};
  wire [1:0] par = {|(nozzle_heat & EVEN_M[NOZ-1:0]), |(nozzle_heat & ~EVEN_M[NOZ-1:0])};
  wire [3:0] col_en = {black_fire_enable, cyan_fire_enable, magenta_fire_enable,
    yellow_fire_enable};
  wire [3:0] band = {|nozzle_heat[NOZ-1:72], |nozzle_heat[71:48], |nozzle_heat[47:24],
    |nozzle_heat[23:0]};
  wire [1:0] warm_in = {warm_heater_drive_1, warm_heater_drive_0};
  wire [1:0] warm_out = {warm_heater_on_1, warm_heater_on_0};

  always_comb begin
    // outputs freeze while ce is low, so follow checks restart after it
    up_nxt = !ce ? 3'h0 : (ok ? up_r : up_r + 3'h1);
    for (int i = 0; i < NOZ; i++) begin
      slot_m[i] = heat_slot[i % 8];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      up_r <= 3'h0;
    end else begin
      up_r <= up_nxt;
    end
  end

  // ----------
  // properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_sel_held;
    (ok && $stable(sel)) [*4];
  endsequence

  sequence s_clear_held;
    line_latch_clear [*4];
  endsequence

  AST_SLOT_DECODE: assert property (s_sel_held |-> heat_slot == (8'h01 << sel))
    else $error("heat slot does not follow block select");
  AST_HEAT_IN_SLOT: assert property ((nozzle_heat & ~slot_m) == '0)
    else $error("nozzle heated outside its slot");
  AST_PARITY_GATE: assert property (ok |-> (par & ~$past(par_en, 3)) == 2'h0)
    else $error("nozzle heated without its parity enable");
  AST_COLOUR_GATE: assert property (cok |-> (band & ~$past(col_en, 3)) == 4'h0)
    else $error("nozzle heated without its colour enable");
  AST_WARM_FOLLOW: assert property (ok |-> warm_out == $past(warm_in, 3))
    else $error("warm heater outputs do not follow drives");
  AST_SUB_FOLLOW: assert property (ok |-> sub_heater_on == $past(sub_heater_drive, 3))
    else $error("sub heater output does not follow drive");
  AST_TYPE_ID: assert property ({head_type_sense_1, head_type_sense_0} ==
    (COLOUR_HEAD ? 2'h2 : 2'h3))
    else $error("head type lines wrong");
  AST_CLEAR_OFF: assert property (s_clear_held |=> nozzle_heat == '0)
    else $error("nozzle heated while latch clear held");
endmodule

bind ihsl_head ihsl_head_monitor #(.COLOUR_HEAD(COLOUR_HEAD), .NOZ(NOZ)) u_mon (
  .clk, .rstn, .ce, .line_latch_clear, .block_select_0, .block_select_1, .block_select_2,
  .yellow_fire_enable, .magenta_fire_enable, .cyan_fire_enable, .black_fire_enable,
  .even_nozzle_fire_enable, .odd_nozzle_fire_enable, .warm_heater_drive_0,
  .warm_heater_drive_1, .sub_heater_drive, .nozzle_heat, .heat_slot, .warm_heater_on_0,
  .warm_heater_on_1, .sub_heater_on, .head_type_sense_0, .head_type_sense_1
);

//--- bench/tb.sv
// self-checking bench of ihsl_head as a colour head and as a black head
// assumes ihsl_board drives the link side and the monitor is bound in
`timescale 1ns/1ps

module tb
  import ihsl_pkg::*;
();
  localparam int NOZ = 136;
  logic clk, rstn, ce, print_shift_clock, serial_print_bit, line_latch_strobe;
  logic line_latch_clear, block_select_0, block_select_1, block_select_2;
  logic yellow_fire_enable, magenta_fire_enable, cyan_fire_enable, black_fire_enable;
  logic even_nozzle_fire_enable, odd_nozzle_fire_enable, sub_heater_drive;
  logic warm_heater_drive_0, warm_heater_drive_1, warm_heater_on_0, warm_heater_on_1;
  logic sub_heater_on, head_type_sense_0, head_type_sense_1, reg_wr, reg_rd;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [NOZ-1:0] nozzle_heat, lat;
  logic [7:0] heat_slot;
  logic [143:0] pat;
  int n_errors, checks_done;
  logic [31:0] rdata_k, rvk;
  logic [127:0] heat_k;
  logic id_k0, id_k1;

  ihsl_head #(.COLOUR_HEAD(1'b1)) dut (
    .clk, .rstn, .ce, .print_shift_clock, .serial_print_bit, .line_latch_strobe,
    .line_latch_clear, .block_select_0, .block_select_1, .block_select_2,
    .yellow_fire_enable, .magenta_fire_enable, .cyan_fire_enable, .black_fire_enable,
    .even_nozzle_fire_enable, .odd_nozzle_fire_enable, .warm_heater_drive_0,
    .warm_heater_drive_1, .sub_heater_drive, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .nozzle_heat, .heat_slot, .warm_heater_on_0, .warm_heater_on_1,
    .sub_heater_on, .head_type_sense_0, .head_type_sense_1
  );
  ihsl_head #(.COLOUR_HEAD(1'b0)) dut_mono (
    .clk, .rstn, .ce, .print_shift_clock, .serial_print_bit, .line_latch_strobe,
    .line_latch_clear, .block_select_0, .block_select_1, .block_select_2,
    .yellow_fire_enable, .magenta_fire_enable, .cyan_fire_enable, .black_fire_enable,
    .even_nozzle_fire_enable, .odd_nozzle_fire_enable, .warm_heater_drive_0,
    .warm_heater_drive_1, .sub_heater_drive, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata(rdata_k), .nozzle_heat(heat_k), .heat_slot(), .warm_heater_on_0(),
    .warm_heater_on_1(), .sub_heater_on(), .head_type_sense_0(id_k0),
    .head_type_sense_1(id_k1)
  );
  ihsl_board board (.clk, .print_shift_clock, .serial_print_bit, .line_latch_strobe);

  always #2.5 clk = ~clk;

  // ----------
  // shared tasks
  // ----------
  task automatic cmp(input string what, input logic [135:0] exp, input logic [135:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr32(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd32(input logic [5:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    rvk = rdata_k;
  endtask

  task automatic rd_latch(output logic [NOZ-1:0] l);
    logic [159:0] w;
    for (int k = 0; k < 5; k++) begin
      rd32(6'h10 + 6'(4 * k));
      w[32*k +: 32] = rv;
    end
    cmp("latch top", 136'h0, 136'(w[159:NOZ]));
    l = w[NOZ-1:0];
  endtask

  task automatic pins(input logic [2:0] s, input logic [3:0] c, input logic [1:0] p,
      input logic [2:0] h, input logic cl);
    @(posedge clk);
    {block_select_2, block_select_1, block_select_0} <= s;
    {black_fire_enable, cyan_fire_enable, magenta_fire_enable, yellow_fire_enable} <= c;
    {even_nozzle_fire_enable, odd_nozzle_fire_enable} <= p;
    {sub_heater_drive, warm_heater_drive_1, warm_heater_drive_0} <= h;
    line_latch_clear <= cl;
    repeat (5) @(posedge clk);
    #1;
  endtask

  function automatic logic [NOZ-1:0] fire(input logic [NOZ-1:0] l, input logic [2:0] s,
      input logic [3:0] c, input logic [1:0] p, input logic k);
    fire = '0;
    for (int i = 0; i < NOZ; i++) begin
      // black head: two enable lines, 64 nozzles each
      fire[i] = l[i] && (i % 8 == s) && p[i % 2]
                && c[k ? i / 64 : (i < 72 ? i / 24 : 3)];
    end
  endfunction

  // ----------
  // scenarios
  // ----------
  task automatic t_regs();
    rd32(6'h00);
    cmp("ctrl", 136'h1, 136'(rv));
    rd32(6'h04);
    cmp("status id", 136'h6, 136'(rv[3:0]));
    cmp("id pins", 136'h2, 136'({head_type_sense_1, head_type_sense_0}));
    cmp("status id mono", 136'h3, 136'(rvk[3:0]));
    cmp("id pins mono", 136'h3, 136'({id_k1, id_k0}));
    rd32(6'h08);
    cmp("lines", 136'h0, 136'(rv));
    wr32(6'h3C, 32'hFFFF_FFFF);
    rd32(6'h3C);
    cmp("unmapped", 136'h0, 136'(rv));
  endtask

  task automatic t_shift();
    pins(3'h0, 4'h0, 2'h0, 3'h0, 1'b0);
    board.load_line(pat, 144);
    rd_latch(lat);
    cmp("latch", pat[143:8], lat);
    rd32(6'h08);
    cmp("lines", 136'h1, 136'(rv));
  endtask

  task automatic t_fire();
    logic [3:0] cm;
    logic [1:0] pm;
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 4; c++) begin
        cm = 4'h1 << c;
        pm = 2'(c % 3 + 1);
        pins(3'(s), cm, pm, 3'h0, 1'b0);
        cmp("slot", 136'(8'h01 << s), 136'(heat_slot));
        cmp("heat", fire(lat, 3'(s), cm, pm, 1'b0), nozzle_heat);
        cmp("heat mono", fire(136'(pat[143:16]), 3'(s), cm, pm, 1'b1), 136'(heat_k));
      end
    end
  endtask

  task automatic t_heat();
    for (int h = 0; h < 8; h++) begin
      pins(3'h0, 4'h0, 2'h0, 3'(h), 1'b0);
      cmp("heaters", 136'(h), 136'({sub_heater_on, warm_heater_on_1, warm_heater_on_0}));
    end
    @(posedge clk);
    ce <= 1'b0;
    pins(3'h0, 4'h0, 2'h0, 3'h0, 1'b0);
    cmp("heaters frozen", 136'h7, 136'({sub_heater_on, warm_heater_on_1, warm_heater_on_0}));
    @(posedge clk);
    ce <= 1'b1;
  endtask

  task automatic t_clear();
    pins(3'h0, 4'h0, 2'h0, 3'h0, 1'b1);
    board.load_line(pat, 136);
    rd_latch(lat);
    cmp("cleared latch", 136'h0, lat);
    rd32(6'h08);
    cmp("lines", 136'h1, 136'(rv));
    pins(3'h0, 4'hF, 2'h3, 3'h0, 1'b0);
    cmp("heat after clear", 136'h0, nozzle_heat);
    pins(3'h0, 4'h0, 2'h0, 3'h0, 1'b0);
    board.load_line(pat, 136);
    pins(3'h0, 4'hF, 2'h3, 3'h0, 1'b0);
    cmp("heat reload", fire(pat[135:0], 3'h0, 4'hF, 2'h3, 1'b0), nozzle_heat);
    cmp("heat mono", fire(136'(pat[135:8]), 3'h0, 4'hF, 2'h3, 1'b1), 136'(heat_k));
    wr32(6'h00, 32'h0000_0000);
    pins(3'h0, 4'hF, 2'h3, 3'h0, 1'b0);
    cmp("heat blocked", 136'h0, nozzle_heat);
    wr32(6'h00, 32'h0000_0003);
    rd32(6'h00);
    cmp("ctrl", 136'h1, 136'(rv));
    rd_latch(lat);
    cmp("sw clear", 136'h0, lat);
  endtask

  task automatic summarize();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    {rstn, line_latch_clear, block_select_2, block_select_1, block_select_0} = '0;
    {yellow_fire_enable, magenta_fire_enable, cyan_fire_enable, black_fire_enable} = '0;
    {even_nozzle_fire_enable, odd_nozzle_fire_enable, sub_heater_drive, reg_wr} = '0;
    {warm_heater_drive_0, warm_heater_drive_1, reg_rd, reg_addr, reg_wdata} = '0;
    clk = 1'b0;
    ce = 1'b1;
    n_errors = 0;
    checks_done = 0;
    pat = {16{9'h1B5}};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_shift();
    t_fire();
    t_heat();
    t_clear();
    summarize();
  end

  initial begin
    #400000;
    n_errors++;
    $display("CHECK FAILED run time expected end seen limit");
    summarize();
  end
endmodule

//--- design/ihsl_defines.svh
// constants of the head shift/latch driver: sizes, nozzle map, register map, resets
// assumes inclusion by bare name from the package and the design modules
`ifndef IHSL_DEFINES_SVH
`define IHSL_DEFINES_SVH

// -----------------------------------------------------------------
// nozzle counts and colour map (zero based nozzle index)
// -----------------------------------------------------------------
`define IHSL_BLACK_NOZZLES 136'd128
`define IHSL_COLOUR_NOZZLES 136'd136
`define IHSL_BLACK_N 128
`define IHSL_COLOUR_N 136
`define IHSL_MAG_FIRST 24
`define IHSL_CYA_FIRST 48
`define IHSL_BLK_FIRST 72
`define IHSL_MONO_SPLIT 64

// -----------------------------------------------------------------
// decoder and synchroniser
// -----------------------------------------------------------------
`define IHSL_SEL_W 3
`define IHSL_SLOTS 8
`define IHSL_PIN_W 14

// -----------------------------------------------------------------
// register map (byte addresses) and reset values
// -----------------------------------------------------------------
`define IHSL_ADDR_W 6
`define IHSL_OFS_CTRL 6'h00
`define IHSL_OFS_STATUS 6'h04
`define IHSL_OFS_LINES 6'h08
`define IHSL_OFS_LATCH0 6'h10
`define IHSL_LATCH_WORDS 5
`define IHSL_CTRL_RESET 32'h0000_0001
`define IHSL_CTRL_PERMIT 0
`define IHSL_CTRL_CLEAR 1
`define IHSL_LINES_W 16

`endif

//--- design/ihsl_head.sv
// head shift register, line latch, block decoder and nozzle heat gating
// assumes a logic board drives the head pins and a local register master
//
// Function
// (RULE1) shift one data bit per transfer clock
// (RULE2) strobe copies whole shift register to latch
// (RULE3) three block selects feed 3-to-8 decoder
// (RULE4) even/odd enables gate matching parity nozzles
// (RULE5) board drives colour enables per head type
// (RULE6) colour head: 24 Y,M,C then 64 K
// (RULE7) black head: 128 nozzles, one bit each
// (RULE8) two inputs drive temperature-control heater
// (RULE9) one input drives the sub heater
// (RULE10) two id lines tell head type
// (RULE11) latch clear forces every bit no-fire
// (RULE12) board holds heat off during load
// (RULE13) decoder splits heat period into eight slots
// (RULE14) fire needs slot, parity, colour, data
// (RULE15) id: black high/high, colour low/high
`timescale 1ns/1ps
`include "ihsl_defines.svh"

module ihsl_head
  import ihsl_pkg::*;
#(
  parameter bit COLOUR_HEAD = 1'b1,
  parameter int NOZ = COLOUR_HEAD ? `IHSL_COLOUR_N : `IHSL_BLACK_N
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic print_shift_clock,
  input wire logic serial_print_bit,
  input wire logic line_latch_strobe,
  input wire logic line_latch_clear,
  input wire logic block_select_0,
  input wire logic block_select_1,
  input wire logic block_select_2,
  input wire logic yellow_fire_enable,
  input wire logic magenta_fire_enable,
  input wire logic cyan_fire_enable,
  input wire logic black_fire_enable,
  input wire logic even_nozzle_fire_enable,
  input wire logic odd_nozzle_fire_enable,
  input wire logic warm_heater_drive_0,
  input wire logic warm_heater_drive_1,
  input wire logic sub_heater_drive,
  input wire logic [`IHSL_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [NOZ-1:0] nozzle_heat,
  output logic [`IHSL_SLOTS-1:0] heat_slot,
  output logic warm_heater_on_0,
  output logic warm_heater_on_1,
  output logic sub_heater_on,
  output logic head_type_sense_0,
  output logic head_type_sense_1
);

  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------
  function automatic ihsl_slot_t slot_decode(input ihsl_sel_t sel);
    ihsl_slot_t s;
    s = '0;
    s[sel] = 1'b1;
    return s;
  endfunction

  function automatic ihsl_ink_t ink_of(input int idx);
    ihsl_ink_t k;
    k = ihsl_ink_black;
    if (COLOUR_HEAD) begin
      if (idx < `IHSL_MAG_FIRST) begin
        k = ihsl_ink_yellow;
      end else if (idx < `IHSL_CYA_FIRST) begin
        k = ihsl_ink_magenta;
      end else if (idx < `IHSL_BLK_FIRST) begin
        k = ihsl_ink_cyan;
      end else begin
        k = ihsl_ink_black;
      end
    end else begin
      // only two colour enable lines reach a black head
      if (idx < `IHSL_MONO_SPLIT) begin
        k = ihsl_ink_yellow;
      end else begin
        k = ihsl_ink_magenta;
      end
    end
    return k;
  endfunction

  function automatic logic [31:0] latch_word(input logic [NOZ-1:0] v, input int w);
    logic [31:0] r;
    r = '0;
    for (int b = 0; b < 32; b++) begin
      if (w * 32 + b < NOZ) begin
        r[b] = v[w * 32 + b];
      end
    end
    return r;
  endfunction

  // -----------------------------------------------------------------
  // link domain: serial shift register
  // -----------------------------------------------------------------
  logic [NOZ-1:0] shift_r;
  logic [NOZ-1:0] shift_nxt;

  always_comb begin
    // first bit of a line ends at nozzle 1 after NOZ clocks
    shift_nxt = {serial_print_bit, shift_r[NOZ-1:1]}; // RULE1 RULE7
  end

  always_ff @(posedge print_shift_clock or negedge rstn) begin
    if (!rstn) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // -----------------------------------------------------------------
  // crossings into clk domain
  // -----------------------------------------------------------------
  logic [NOZ-1:0] data_s;
  logic [`IHSL_PIN_W-1:0] pins_raw;
  logic [`IHSL_PIN_W-1:0] pins_s;

  // the shift clock is stopped before the strobe, so the bus is quiet
  ihsl_sync #(.W(NOZ)) u_data_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .d(shift_r),
    .q(data_s)
  );

  assign pins_raw = {line_latch_strobe, line_latch_clear,
                     block_select_2, block_select_1, block_select_0,
                     black_fire_enable, cyan_fire_enable,
                     magenta_fire_enable, yellow_fire_enable,
                     odd_nozzle_fire_enable, even_nozzle_fire_enable,
                     warm_heater_drive_1, warm_heater_drive_0, sub_heater_drive};

  ihsl_sync #(.W(`IHSL_PIN_W)) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .d(pins_raw),
    .q(pins_s)
  );

  logic strobe_s;
  logic clear_s;
  ihsl_sel_t sel_s;
  ihsl_ink_t ink_en_s;
  logic odd_s;
  logic even_s;
  logic ht1_s;
  logic ht0_s;
  logic sub_s;

  assign strobe_s = pins_s[13];
  assign clear_s = pins_s[12];
  assign sel_s = pins_s[11:9]; // RULE3
  assign ink_en_s = ihsl_ink_t'(pins_s[8:5]); // RULE5
  assign odd_s = pins_s[4];
  assign even_s = pins_s[3];
  assign ht1_s = pins_s[2];
  assign ht0_s = pins_s[1];
  assign sub_s = pins_s[0];

  // -----------------------------------------------------------------
  // register port
  // -----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic soft_clear;
  logic fire_permit;
  logic [`IHSL_LINES_W-1:0] lines_r;
  logic [NOZ-1:0] latch_r;
  ihsl_slot_t slot_r;
  logic [1:0] id_r;

  assign fire_permit = ctrl_r[`IHSL_CTRL_PERMIT];

  always_comb begin
    ctrl_nxt = ctrl_r;
    soft_clear = 1'b0;
    if (reg_wr && reg_addr == `IHSL_OFS_CTRL) begin
      ctrl_nxt = '0;
      ctrl_nxt[`IHSL_CTRL_PERMIT] = reg_wdata[`IHSL_CTRL_PERMIT];
      soft_clear = reg_wdata[`IHSL_CTRL_CLEAR];
    end
  end

  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      if (reg_addr == `IHSL_OFS_CTRL) begin
        rdata_nxt = ctrl_r;
      end else if (reg_addr == `IHSL_OFS_STATUS) begin
        rdata_nxt[1:0] = id_r;
        rdata_nxt[2] = COLOUR_HEAD;
        rdata_nxt[3] = clear_s;
        rdata_nxt[15:8] = slot_r;
      end else if (reg_addr == `IHSL_OFS_LINES) begin
        rdata_nxt[`IHSL_LINES_W-1:0] = lines_r;
      end else begin
        for (int w = 0; w < `IHSL_LATCH_WORDS; w++) begin
          if (reg_addr == `IHSL_OFS_LATCH0 + 6'(w * 4)) begin
            rdata_nxt = latch_word(latch_r, w);
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `IHSL_CTRL_RESET;
      rdata_r <= '0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // -----------------------------------------------------------------
  // line latch
  // -----------------------------------------------------------------
  logic strobe_d_r;
  logic [NOZ-1:0] latch_nxt;
  logic [`IHSL_LINES_W-1:0] lines_nxt;
  logic strobe_rise;

  assign strobe_rise = strobe_s & ~strobe_d_r;

  always_comb begin
    latch_nxt = latch_r;
    lines_nxt = lines_r;
    if (clear_s || soft_clear) begin
      latch_nxt = '0; // RULE11
    end else if (strobe_rise) begin
      // board strobes only after a full line has been shifted
      latch_nxt = data_s; // RULE2
      lines_nxt = lines_r + `IHSL_LINES_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_d_r <= 1'b0;
      latch_r <= '0;
      lines_r <= '0;
    end else if (ce) begin
      strobe_d_r <= strobe_s;
      latch_r <= latch_nxt;
      lines_r <= lines_nxt;
    end
  end

  // -----------------------------------------------------------------
  // decoder and nozzle heat gating
  // -----------------------------------------------------------------
  ihsl_slot_t slot_nxt;
  logic [NOZ-1:0] heat_r;
  logic [NOZ-1:0] heat_nxt;

  always_comb begin
    slot_nxt = slot_decode(sel_s); // RULE3 RULE13
    heat_nxt = '0;
    for (int i = 0; i < NOZ; i++) begin
      // nozzle i+1: even number when i is odd
      heat_nxt[i] = latch_r[i]
                    & slot_nxt[i % `IHSL_SLOTS]
                    & ((i % 2 == 1) ? even_s : odd_s) // RULE4
                    & |(ink_en_s & ink_of(i)) // RULE6 RULE7
                    & fire_permit
                    & ~clear_s; // RULE14
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slot_r <= '0;
      heat_r <= '0;
    end else if (ce) begin
      slot_r <= slot_nxt;
      heat_r <= heat_nxt;
    end
  end

  assign heat_slot = slot_r;
  assign nozzle_heat = heat_r;

  // -----------------------------------------------------------------
  // heaters and identification
  // -----------------------------------------------------------------
  logic ht0_r;
  logic ht1_r;
  logic sub_r;
  logic ht0_nxt;
  logic ht1_nxt;
  logic sub_nxt;
  logic [1:0] id_nxt;

  always_comb begin
    ht0_nxt = ht0_s; // RULE8
    ht1_nxt = ht1_s; // RULE8
    sub_nxt = sub_s; // RULE9
    // bit0 first line, bit1 second line
    id_nxt = COLOUR_HEAD ? 2'b10 : 2'b11; // RULE10 RULE15
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ht0_r <= 1'b0;
      ht1_r <= 1'b0;
      sub_r <= 1'b0;
      id_r <= COLOUR_HEAD ? 2'b10 : 2'b11;
    end else if (ce) begin
      ht0_r <= ht0_nxt;
      ht1_r <= ht1_nxt;
      sub_r <= sub_nxt;
      id_r <= id_nxt;
    end
  end

  assign warm_heater_on_0 = ht0_r;
  assign warm_heater_on_1 = ht1_r;
  assign sub_heater_on = sub_r;
  assign head_type_sense_0 = id_r[0];
  assign head_type_sense_1 = id_r[1];

endmodule

//--- design/ihsl_pkg.sv
// types shared by the head shift/latch driver modules
// assumes ihsl_defines.svh is on the include path
`include "ihsl_defines.svh"

package ihsl_pkg;

  // ink colour of a nozzle, one-hot
  typedef enum logic [3:0] {
    ihsl_ink_yellow  = 4'b0001,
    ihsl_ink_magenta = 4'b0010,
    ihsl_ink_cyan    = 4'b0100,
    ihsl_ink_black   = 4'b1000
  } ihsl_ink_t;

  // one-hot heat timing slot
  typedef logic [`IHSL_SLOTS-1:0] ihsl_slot_t;

  // block select code
  typedef logic [`IHSL_SEL_W-1:0] ihsl_sel_t;

endpackage

//--- design/ihsl_sync.sv
// two flip-flop synchroniser for a bus of levels
// assumes the bus is quiet long enough for all bits to settle together
`timescale 1ns/1ps
`include "ihsl_defines.svh"

module ihsl_sync
  import ihsl_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // -----------------------------------------------------------------
  // two stages, first read only by second
  // -----------------------------------------------------------------
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q_r <= '0;
    end else if (ce) begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
